// ===== logic/rdtov_defs.svh
// constants of the residual definite-time overvoltage element
`ifndef RDTOV_DEFS_SVH
`define RDTOV_DEFS_SVH

// ==========================================================
// measurement scaling
`define RDTOV_RMS_W 16
`define RDTOV_RMS_PER_PCT 16'h0064

// ==========================================================
// start threshold setting, percent of rated voltage
`define RDTOV_THR_MIN 7'h02
`define RDTOV_THR_MAX 7'h3c
`define RDTOV_THR_DEF 7'h1e

// ==========================================================
// operate delay setting, milliseconds
`define RDTOV_DELAY_MAX 16'hea60
`define RDTOV_DELAY_DEF 16'h0064

// ==========================================================
// operation and start-only defaults
`define RDTOV_OPER_DEF 1'b1
`define RDTOV_START_ONLY_DEF 1'b0

// ==========================================================
// timing
`define RDTOV_CLK_PERIOD_NS 8
`define RDTOV_MS_TIME_NS 1000000
`define RDTOV_RESET_TO_RATED_MS 60
`define RDTOV_RESET_TO_ZERO_MS 50
`define RDTOV_OPERATE_MS 50

`endif

// ===== logic/rdtov_pkg.sv
// types of the residual definite-time overvoltage element
package rdtov_pkg;

   // ==========================================================
   // timing phase, gray coded along idle, timing, tripped
   typedef enum logic [1:0] {
      RDTOV_IDLE    = 2'h0,
      RDTOV_TIMING  = 2'h1,
      RDTOV_TRIPPED = 2'h3
   } rdtov_phase_type;

   // ==========================================================
   // settings applied by the user
   typedef struct packed {
      logic operation_setting;
      logic start_only_select;
      logic [6:0] start_threshold_pct;
      logic [15:0] operate_delay_ms;
   } rdtov_settings_type;

   // ==========================================================
   // general outputs
   typedef struct packed {
      logic general_start_out;
      logic general_trip_out;
   } rdtov_status_type;

   // ==========================================================
   // state of the element, apart from the prescaler count
   typedef struct packed {
      rdtov_phase_type phase;
      logic [15:0] ms_count;
      rdtov_status_type status;
   } rdtov_state_type;

endpackage

// ===== logic/rdtov_ms_tick.sv
// millisecond tick divider with restart
`timescale 1ns/10ps
module rdtov_ms_tick #(
   parameter int MS_CYCLES = 125000
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // control
   input wire logic i_clear,
   // tick
   output logic o_tick
);

   logic [19:0] count;
   logic [19:0] next_count;
   logic wrap;

   // one-cycle tick each time a full millisecond has elapsed
   assign wrap = (count == 20'(MS_CYCLES - 1));
   assign o_tick = wrap && !i_clear;

   // prescaler restarts from zero whenever cleared
   always_comb begin
      if (i_clear || wrap) begin
         next_count = 20'h00000;
      end else begin
         next_count = count + 20'h00001;
      end
   end

   // register
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         count <= 20'h00000;
      end else begin
         count <= next_count;
      end
   end

endmodule

// ===== logic/rdtov_element.sv
// residual definite-time overvoltage element: characteristic and decision logic
`timescale 1ns/10ps
`include "rdtov_defs.svh"

// Functional notes
// - start is raised while the residual voltage exceeds the threshold, and the delay runs only then.
// - the threshold is a percent of rated voltage, 2 to 60 in unit steps, default 30.
// - after start a delay of 0 to 60000 ms (default 100) is counted and then trip is raised.
// - the operation setting (Off or On, default On) suppresses general start and trip while Off.
// - with start-only set (default false) start still works but the general trip is never given.
// - an external block input disables the element so that no general start or trip is driven.
// - the general start output is the start after enable and blocking have been applied.
// - the general trip output is the timed trip gated by enable, blocking and start-only.
// - internal start and trip status feed the decision logic and also drive the observation outputs directly.
// - the element resets within 60 ms (to rated) or 50 ms (to zero); operate about 50 ms.
// - start-only at zero gives start and trip; at one gives start indication only.
module rdtov_element #(
   parameter int MS_CYCLES = `RDTOV_MS_TIME_NS / `RDTOV_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // measurement, in hundredths of a percent of rated voltage
   input wire logic [`RDTOV_RMS_W-1:0] i_residual_rms_fundamental,
   // settings
   input wire rdtov_pkg::rdtov_settings_type i_settings,
   // user blocking
   input wire logic i_block_input,
   // general outputs
   output rdtov_pkg::rdtov_status_type o_status,
   // internal status, for observation
   output logic o_residual_start_internal,
   output logic o_residual_trip_internal
);
   import rdtov_pkg::*;

   // ==========================================================
   // declarations
   rdtov_state_type state;
   rdtov_state_type next_state;
   logic [6:0] thr_pct;
   logic [15:0] thr_units;
   logic [15:0] delay_ms;
   logic above;
   logic enabled;
   logic ms_tick;
   logic tick_clear;
   logic residual_start_internal;
   logic residual_trip_internal;

   // ==========================================================
   // settings conditioning
   // threshold held to its legal range
   always_comb begin
      if (i_settings.start_threshold_pct < `RDTOV_THR_MIN) begin
         thr_pct = `RDTOV_THR_MIN;
      end else if (i_settings.start_threshold_pct > `RDTOV_THR_MAX) begin
         thr_pct = `RDTOV_THR_MAX;
      end else begin
         thr_pct = i_settings.start_threshold_pct;
      end
   end

   // threshold in measurement units
   assign thr_units = 16'({9'h000, thr_pct} * `RDTOV_RMS_PER_PCT);

   // delay held to at most its maximum
   assign delay_ms = (i_settings.operate_delay_ms > `RDTOV_DELAY_MAX) ?
                     `RDTOV_DELAY_MAX : i_settings.operate_delay_ms;

   // ==========================================================
   // characteristic
   // value from the upstream stage, same clock, no synchroniser
   // strict excess over the threshold starts the element
   assign above = (i_residual_rms_fundamental > thr_units);

   assign enabled = i_settings.operation_setting && !i_block_input;

   // prescaler restarts whenever timing is not running
   assign tick_clear = !above || !enabled;

   // millisecond time base
   rdtov_ms_tick #(
      .MS_CYCLES(MS_CYCLES)
   ) u_ms_tick (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_clear(tick_clear),
      .o_tick(ms_tick)
   );

   // internal status signals of the characteristic
   assign residual_start_internal = above;
   // trip once the counted delay has expired while still started
   assign residual_trip_internal = above && (state.ms_count >= delay_ms);

   // ==========================================================
   // next state
   always_comb begin
      next_state = state;
      // drop below threshold or disable clears the timer
      if (tick_clear) begin
         next_state.phase = RDTOV_IDLE;
         next_state.ms_count = 16'h0000;
      end else begin
         case (state.phase)
            RDTOV_IDLE: begin
               next_state.phase = RDTOV_TIMING;
            end
            RDTOV_TIMING: begin
               if (residual_trip_internal) begin
                  next_state.phase = RDTOV_TRIPPED;
               end
            end
            RDTOV_TRIPPED: begin
               next_state.phase = RDTOV_TRIPPED;
            end
            default: begin
               next_state.phase = RDTOV_IDLE;
            end
         endcase
         // delay advances one step per millisecond while started
         if (ms_tick && (state.ms_count < delay_ms)) begin
            next_state.ms_count = state.ms_count + 16'h0001;
         end
      end
      // general start after enable and blocking
      // start falls one cycle after a drop
      next_state.status.general_start_out = enabled && residual_start_internal;
      // general trip gated by enable and blocking
      // start-only at one bars trip, at zero lets it through
      next_state.status.general_trip_out = enabled && !i_settings.start_only_select &&
                                           residual_trip_internal;
   end

   // ==========================================================
   // register
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // outputs
   assign o_status = state.status;
   assign o_residual_start_internal = residual_start_internal;
   assign o_residual_trip_internal = residual_trip_internal;

   // ==========================================================
   // assertions
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);

   // voltage falls away from above threshold
   sequence s_drop;
      above ##1 !above;
   endsequence

   // enabled excess of threshold
   sequence s_started;
      above && enabled;
   endsequence

   // start follows the excess in one cycle
   a_start_follows: assert property (s_started |=> o_status.general_start_out)
      else $error("general start missing after threshold excess");

   a_thr_range: assert property (thr_pct >= 7'h02 && thr_pct <= 7'h3c)
      else $error("threshold outside 2 to 60 percent");

   // expiry with start gives trip next cycle
   a_trip_expiry: assert property (
      (above && enabled && (state.ms_count >= delay_ms) && !i_settings.start_only_select)
      |=> o_status.general_trip_out)
      else $error("trip missing after delay expiry");

   // counter steps by one on a tick
   a_count_step: assert property (
      (above && enabled && ms_tick && (state.ms_count < delay_ms))
      |=> state.ms_count == $past(state.ms_count) + 16'h0001)
      else $error("delay counter did not advance on tick");

   a_oper_off: assert property (!i_settings.operation_setting |=>
      !o_status.general_start_out && !o_status.general_trip_out)
      else $error("output active while operation off");

   a_start_only: assert property (i_settings.start_only_select |=>
      !o_status.general_trip_out)
      else $error("trip given in start-only mode");

   a_block_quiet: assert property (i_block_input |=>
      !o_status.general_start_out && !o_status.general_trip_out)
      else $error("output active while blocked");

   // trip is never shown without start
   a_trip_with_start: assert property (o_status.general_trip_out |->
      o_status.general_start_out)
      else $error("trip without start");

   // trip only shown while the phase machine runs
   a_phase_live: assert property (o_status.general_trip_out |->
      state.phase != RDTOV_IDLE)
      else $error("trip shown while timing idle");

   // drop releases start within one cycle
   a_drop_reset: assert property (s_drop |=> !o_status.general_start_out)
      else $error("start held after voltage drop");

   a_drop_clears: assert property (s_drop |=> state.ms_count == 16'h0000)
      else $error("delay counter not cleared on drop");

   // no trip for eight cycles after a fresh start with nonzero delay
   a_fresh_no_trip: assert property (
      ($rose(above) && delay_ms != 16'h0000) |-> !residual_trip_internal [*8])
      else $error("trip without elapsed delay");

endmodule

// ===== testbench/rdtov_upstream_model.sv
// model of the upstream measurement stage and user blocking logic
`timescale 1ns/10ps
`include "rdtov_defs.svh"
module rdtov_upstream_model (
   // commands from the bench
   input wire logic [`RDTOV_RMS_W-1:0] i_level,
   input wire logic i_block_request,
   // towards the element
   output logic [`RDTOV_RMS_W-1:0] o_residual_rms_fundamental,
   output logic o_block_input
);
   // ====
   // measurement hand-on
   // settled fundamental rms, always valid
   always_comb begin
      o_residual_rms_fundamental = i_level;
   end
   // user block equation
   // equation output, active high
   always_comb begin
      o_block_input = i_block_request;
   end
endmodule

// ===== testbench/tb_top.sv
// self-checking bench of the residual overvoltage element
`timescale 1ns/10ps
`include "rdtov_defs.svh"
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp); end end
module tb_top;
   import rdtov_pkg::*;
   localparam int N = 10;
   logic i_core_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [15:0] level = 16'h0000;
   logic block_req = 1'b0;
   rdtov_settings_type settings = '0;
   logic [15:0] rms;
   logic blk;
   rdtov_status_type status;
   logic st_int;
   logic tr_int;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   // ====
   // clock, 8 ns period
   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end
   // far side and element
   rdtov_upstream_model partner (.i_level(level), .i_block_request(block_req),
      .o_residual_rms_fundamental(rms), .o_block_input(blk));
   rdtov_element #(.MS_CYCLES(N)) dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .i_residual_rms_fundamental(rms), .i_settings(settings), .i_block_input(blk),
      .o_status(status), .o_residual_start_internal(st_int),
      .o_residual_trip_internal(tr_int));
   // hang guard
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   // ====
   task automatic finish_test();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic fall(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   // idle the element, then apply new settings
   task automatic arm(input logic [6:0] thr, input logic [15:0] dly, input logic op,
                      input logic so);
      level = 16'h0000;
      block_req = 1'b0;
      settings = '{op, so, thr, dly};
      fall(2);
   endtask
   // ====
   // exact start and trip moments for a delay in ms
   task automatic t_timing(input logic [6:0] thr, input logic [15:0] dly);
      arm(thr, dly, `RDTOV_OPER_DEF, `RDTOV_START_ONLY_DEF);
      level = thr * 16'h0064 + 16'h0001;
      fall(1);
      `CHK(status, 2'h2)
      `CHK(st_int, 1'b1)
      fall(int'(dly) * N - 2);
      `CHK(tr_int, 1'b0)
      fall(1);
      `CHK(tr_int, 1'b1)
      `CHK(status.general_trip_out, 1'b0)
      fall(1);
      `CHK(status, 2'h3)
      level = 16'h0000;
      fall(1);
      `CHK(status, 2'h0)
   endtask
   // zero delay trips with start
   task automatic t_zero();
      arm(7'h1e, 16'h0000, 1'b1, 1'b0);
      level = 16'h0bb9;
      fall(1);
      `CHK(status, 2'h3)
   endtask
   // strict compare and threshold clamping
   task automatic t_threshold();
      logic [6:0] thr [8] = '{7'h1e, 7'h1e, 7'h01, 7'h01, 7'h02, 7'h46, 7'h46, 7'h3c};
      logic [15:0] lv [8] = '{16'h0bb8, 16'h0bb9, 16'h00c8, 16'h00c9, 16'h00c8, 16'h1770,
                             16'h1771, 16'h1771};
      logic ex [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      for (int k = 0; k < 8; k++) begin
         arm(thr[k], 16'h03e8, 1'b1, 1'b0);
         level = lv[k];
         fall(1);
         `CHK(status.general_start_out, ex[k])
      end
   endtask
   // drop to threshold restarts timing from zero
   task automatic t_restart();
      arm(7'h1e, 16'h0002, 1'b1, 1'b0);
      level = 16'h0bb9;
      fall(15);
      level = 16'h0bb8;
      fall(1);
      `CHK(status, 2'h0)
      level = 16'h0bb9;
      fall(2 * N);
      `CHK(status, 2'h2)
      fall(1);
      `CHK(status, 2'h3)
   endtask
   // gating by off, block and start-only from the start
   task automatic t_gates();
      logic op [3] = '{1'b0, 1'b1, 1'b1};
      logic so [3] = '{1'b0, 1'b0, 1'b1};
      logic bk [3] = '{1'b0, 1'b1, 1'b0};
      logic [1:0] ex [3] = '{2'h0, 2'h0, 2'h2};
      for (int k = 0; k < 3; k++) begin
         arm(7'h1e, 16'h0001, op[k], so[k]);
         block_req = bk[k];
         level = 16'h0bb9;
         fall(N + 2);
         `CHK(status, ex[k])
      end
   endtask
   // gating changes while tripped, operation off while started
   task automatic t_midrun();
      arm(7'h1e, 16'h0001, 1'b1, 1'b0);
      level = 16'h0bb9;
      fall(N + 2);
      `CHK(status, 2'h3)
      settings.start_only_select = 1'b1;
      fall(1);
      `CHK(status, 2'h2)
      block_req = 1'b1;
      fall(1);
      `CHK(status, 2'h0)
      block_req = 1'b0;
      settings.start_only_select = 1'b0;
      fall(1);
      `CHK(status, 2'h2)
      settings.operation_setting = 1'b0;
      fall(1);
      `CHK(status, 2'h0)
   endtask
   // reset in mid-run, timing restarts from zero afterwards
   task automatic t_reset();
      arm(7'h1e, 16'h0001, 1'b1, 1'b0);
      level = 16'h0bb9;
      fall(N + 2);
      `CHK(status, 2'h3)
      i_reset_n = 1'b0;
      fall(1);
      `CHK(status, 2'h0)
      `CHK(tr_int, 1'b0)
      i_reset_n = 1'b1;
      fall(1);
      `CHK(status, 2'h2)
      fall(N - 1);
      `CHK(status, 2'h2)
      fall(1);
      `CHK(status, 2'h3)
   endtask
   // ====
   // main sequence
   initial begin
      fall(6);
      i_reset_n = 1'b1;
      fall(1);
      t_timing(`RDTOV_THR_DEF, `RDTOV_DELAY_DEF);
      t_timing(7'h1e, 16'h0001);
      t_zero();
      t_threshold();
      t_restart();
      t_gates();
      t_midrun();
      t_reset();
      finish_test();
   end
endmodule
